// >>> logic/pph_regs.svh
// Constants for the printer parallel host port
// Functional notes
// - The host puts a byte on eight data lines and pulses strobe; the port samples the lines on it.
// - The port pulses acknowledge when a data unit is taken outside ECP mode or a requested function has finished.
// - Busy stands while received data is being handled and whenever an alarm is present, except while a nibble is shown on the status lines.
// - Fault is asserted on paper out or alarm, and paper out also shows on paper end, except while a nibble is shown on the status lines.
// - Auto feed and select in together form the host's request to change the interface mode.
// - Three modes: compatibility moves 8 bits, nibble 4 bits, ECP 9 bits (data plus qualifier).
// - The handshake carried out is the one that belongs to the mode currently active.
// - Every data unit taken from the host is written into the receive buffer.
// - Receive buffer capacity is selectable as 8K, 20K, 50K, 100K or 1M bytes.
// - Busy acts as flow control and holds the host off while no more data fits.
`ifndef PPH_REGS_SVH
`define PPH_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PPH_CLK_MHZ     125
`define PPH_ACK_NS      1000
`define PPH_ACK_CYC     ((`PPH_ACK_NS * `PPH_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define PPH_DATA_W      8
`define PPH_UNIT_W      9
`define PPH_FIFO_DEPTH  8
`define PPH_OCC_W       21

// ----------------------------------------
// Receive buffer capacities in bytes
// ----------------------------------------
`define PPH_CAP_8K      21'h00_2000
`define PPH_CAP_20K     21'h00_5000
`define PPH_CAP_50K     21'h00_C800
`define PPH_CAP_100K    21'h01_9000
`define PPH_CAP_1M      21'h10_0000

// ----------------------------------------
// Negotiation byte and synchroniser bit positions
// ----------------------------------------
`define PPH_NEG_NIBBLE  8'h00
`define PPH_NEG_ECP_BIT 4
`define PPH_IN_STB      8
`define PPH_IN_AFD      9
`define PPH_IN_SEL      10
`define PPH_IN_INIT     11
`define PPH_IN_W        12

`endif

// >>> logic/pph_pkg.sv
// Types for the printer parallel host port
`default_nettype none
package pph_pkg;
  typedef enum logic [1:0] {
    PPH_MODE_COMPAT = 2'b00,
    PPH_MODE_NIBBLE = 2'b01,
    PPH_MODE_ECP    = 2'b10
  } pph_mode_t;

  typedef enum logic [2:0] {
    PPH_ST_IDLE    = 3'b000,
    PPH_ST_PUSH    = 3'b001,
    PPH_ST_ACK     = 3'b010,
    PPH_ST_HOLD    = 3'b011,
    PPH_ST_ECP_REL = 3'b100,
    PPH_ST_NIB_REL = 3'b101,
    PPH_ST_NEG     = 3'b110
  } pph_state_t;
endpackage
`default_nettype wire

// >>> logic/pph_fifo.sv
// Small flip-flop FIFO between host side and receive buffer
`default_nettype none
module pph_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // Handshake flags
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  // Register state
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end
endmodule // pph_fifo
`default_nettype wire

// >>> logic/pph_port.sv
// Printer side parallel host port with mode handshakes
`include "pph_regs.svh"
`default_nettype none
module pph_port
  import pph_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Host pins in
  input  wire logic       strobe_n,
  input  wire logic [7:0] data_in,
  input  wire logic       auto_feed_n,
  input  wire logic       select_in,
  input  wire logic       init_n,
  // Status pins out
  output logic            ack_n,
  output logic            busy,
  output logic            paper_end,
  output logic            select,
  output logic            fault_n,
  // Printer conditions and options
  input  wire logic       paper_out,
  input  wire logic       alarm,
  input  wire logic       online,
  input  wire logic       init_enable,
  input  wire logic [2:0] buf_size_sel,
  // Receive stream toward the print buffer
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_command,
  input  wire logic       rx_release,
  // Reverse data for nibble mode
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  // Active mode
  output logic [1:0]      mode
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam logic [7:0] ACK_CYC = 8'(`PPH_ACK_CYC);

  logic [`PPH_IN_W-1:0] in_raw, s1_q, s2_q, s3_q, flt_q, flt_d;
  pph_state_t           st_q, st_d;
  pph_mode_t            mode_q, mode_d;
  logic [8:0]           unit_q, unit_d;
  logic [7:0]           cnt_q, cnt_d;
  logic [3:0]           nib_q, nib_d;
  logic                 nib_hi_q, nib_hi_d;
  logic                 neg_q, neg_d;
  logic [`PPH_OCC_W-1:0] occ_q, occ_d, cap;
  logic ack_n_q, ack_n_d, busy_q, busy_d, pe_q, pe_d;
  logic sel_q, sel_d, flt_n_q, flt_n_d, tx_rdy_q, tx_rdy_d;
  logic stb_fall, stb_high, afd_low, neg_now, init_clr;
  logic push, f_in_ready, f_out_valid, f_out_ready, room, drain;
  logic [8:0] f_out_data;

  // ----------------------------------------
  // Pin synchronisers and agreement filter
  // ----------------------------------------
  assign in_raw = {init_n, select_in, auto_feed_n, strobe_n, data_in};

  // Filtered level follows once stages two and three agree
  always_comb begin
    flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q  <= {`PPH_IN_W{1'b1}};
      s2_q  <= {`PPH_IN_W{1'b1}};
      s3_q  <= {`PPH_IN_W{1'b1}};
      flt_q <= {`PPH_IN_W{1'b1}};
    end else begin
      s1_q  <= in_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  // Events on filtered host lines
  assign stb_fall = flt_q[`PPH_IN_STB] & ~flt_d[`PPH_IN_STB];
  assign stb_high = flt_d[`PPH_IN_STB];
  assign afd_low  = ~flt_d[`PPH_IN_AFD];
  assign neg_now  = flt_d[`PPH_IN_SEL] & afd_low;
  assign init_clr = init_enable & flt_q[`PPH_IN_INIT]
                  & ~flt_d[`PPH_IN_INIT];

  // ----------------------------------------
  // Receive FIFO and buffer occupancy
  // ----------------------------------------
  pph_fifo #(
    .W (`PPH_UNIT_W),
    .D (`PPH_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (init_clr),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (unit_q),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Capacity chosen by the size select
  always_comb begin
    unique case (buf_size_sel)
      3'h0:    cap = `PPH_CAP_8K;
      3'h1:    cap = `PPH_CAP_20K;
      3'h2:    cap = `PPH_CAP_50K;
      3'h3:    cap = `PPH_CAP_100K;
      default: cap = `PPH_CAP_1M;
    endcase
  end

  // Drain only while the print buffer has room
  assign room        = (occ_q < cap);
  assign rx_valid    = f_out_valid & room;
  assign f_out_ready = rx_ready & room;
  assign drain       = f_out_valid & f_out_ready;
  assign rx_data     = f_out_data[7:0];
  assign rx_command  = f_out_data[8];

  // Bytes held in the print buffer
  always_comb begin
    occ_d = occ_q;
    if (drain & ~rx_release) begin
      occ_d = occ_q + 1'b1;
    end else if (~drain & rx_release & (occ_q != '0)) begin
      occ_d = occ_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      occ_q <= '0;
    end else begin
      occ_q <= occ_d;
    end
  end

  // ----------------------------------------
  // Handshake state machine
  // ----------------------------------------
  always_comb begin
    st_d     = st_q;
    mode_d   = mode_q;
    unit_d   = unit_q;
    nib_d    = nib_q;
    nib_hi_d = nib_hi_q;
    neg_d    = neg_now;
    push     = 1'b0;
    tx_rdy_d = 1'b0;
    cnt_d    = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    unique case (st_q)
      PPH_ST_IDLE: begin
        if (mode_q == PPH_MODE_COMPAT && neg_now && !neg_q) begin
          // Only compat negotiates; elsewhere auto feed is the ECP qualifier or the nibble host ready
          if (flt_d[7:0] == `PPH_NEG_NIBBLE) begin
            mode_d = PPH_MODE_NIBBLE;
          end else if (flt_d[`PPH_NEG_ECP_BIT]) begin
            mode_d = PPH_MODE_ECP;
          end else begin
            mode_d = PPH_MODE_COMPAT;
          end
          cnt_d = ACK_CYC;
          st_d  = PPH_ST_NEG;
        end else if (mode_q != PPH_MODE_COMPAT
                     && ~flt_d[`PPH_IN_SEL]) begin
          mode_d   = PPH_MODE_COMPAT;
          nib_hi_d = 1'b0;
        end else if (mode_q == PPH_MODE_NIBBLE) begin
          // Host ready for a nibble
          if (afd_low & tx_valid) begin
            nib_d = nib_hi_q ? tx_data[7:4] : tx_data[3:0];
            cnt_d = ACK_CYC;
            st_d  = PPH_ST_ACK;
          end
        end else if (stb_fall) begin
          // ECP qualifier: auto feed low marks a command
          unit_d = {(mode_q == PPH_MODE_ECP) & afd_low,
                    flt_d[7:0]};
          st_d   = PPH_ST_PUSH;
        end
      end
      PPH_ST_PUSH: begin
        if (f_in_ready) begin
          push  = 1'b1;
          cnt_d = ACK_CYC;
          st_d  = (mode_q == PPH_MODE_ECP) ? PPH_ST_ECP_REL
                                           : PPH_ST_ACK;
        end
      end
      PPH_ST_ACK: begin
        if (cnt_q <= 8'h01) begin
          st_d = (mode_q == PPH_MODE_NIBBLE) ? PPH_ST_NIB_REL
                                             : PPH_ST_HOLD;
        end
      end
      PPH_ST_NEG: begin
        if (cnt_q <= 8'h01) begin
          st_d = PPH_ST_HOLD;
        end
      end
      PPH_ST_HOLD: begin
        if (f_in_ready) begin
          st_d = PPH_ST_IDLE;
        end
      end
      PPH_ST_ECP_REL: begin
        if (stb_high) begin
          st_d = PPH_ST_IDLE;
        end
      end
      PPH_ST_NIB_REL: begin
        if (~afd_low) begin
          tx_rdy_d = nib_hi_q;
          nib_hi_d = ~nib_hi_q;
          st_d     = PPH_ST_IDLE;
        end
      end
      default: st_d = PPH_ST_IDLE;
    endcase
    if (init_clr) begin
      st_d     = PPH_ST_IDLE;
      mode_d   = PPH_MODE_COMPAT;
      nib_hi_d = 1'b0;
      push     = 1'b0;
      tx_rdy_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Status pin values
  // ----------------------------------------
  always_comb begin
    ack_n_d = ~(st_d == PPH_ST_ACK || st_d == PPH_ST_NEG);
    busy_d  = alarm | (st_d != PPH_ST_IDLE) | ~f_in_ready;
    pe_d    = paper_out;
    sel_d   = online;
    flt_n_d = ~(paper_out | alarm);
    if (mode_d == PPH_MODE_NIBBLE
        && (st_d == PPH_ST_ACK || st_d == PPH_ST_NIB_REL)) begin
      flt_n_d = nib_d[0];
      sel_d   = nib_d[1];
      pe_d    = nib_d[2];
      busy_d  = nib_d[3];
    end
  end

  // Register state and pins
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= PPH_ST_IDLE;
      mode_q   <= PPH_MODE_COMPAT;
      unit_q   <= '0;
      cnt_q    <= '0;
      nib_q    <= '0;
      nib_hi_q <= 1'b0;
      neg_q    <= 1'b0;
      tx_rdy_q <= 1'b0;
      ack_n_q  <= 1'b1;
      busy_q   <= 1'b1;
      pe_q     <= 1'b0;
      sel_q    <= 1'b0;
      flt_n_q  <= 1'b1;
    end else begin
      st_q     <= st_d;
      mode_q   <= mode_d;
      unit_q   <= unit_d;
      cnt_q    <= cnt_d;
      nib_q    <= nib_d;
      nib_hi_q <= nib_hi_d;
      neg_q    <= neg_d;
      tx_rdy_q <= tx_rdy_d;
      ack_n_q  <= ack_n_d;
      busy_q   <= busy_d;
      pe_q     <= pe_d;
      sel_q    <= sel_d;
      flt_n_q  <= flt_n_d;
    end
  end

  // Outputs
  assign ack_n     = ack_n_q;
  assign busy      = busy_q;
  assign paper_end = pe_q;
  assign select    = sel_q;
  assign fault_n   = flt_n_q;
  assign tx_ready  = tx_rdy_q;
  assign mode      = mode_q;
endmodule // pph_port
`default_nettype wire

// >>> verification/pph_sva.sv
// Assertion checker for the printer parallel host port
`include "pph_regs.svh"
`default_nettype none
module pph_sva (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Host lines and printer conditions
  input wire logic       strobe_n,
  input wire logic       init_n,
  input wire logic       init_enable,
  input wire logic       paper_out,
  input wire logic       alarm,
  // Status lines and receive stream
  input wire logic       ack_n,
  input wire logic       busy,
  input wire logic       paper_end,
  input wire logic       fault_n,
  input wire logic [1:0] mode,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACK = `PPH_ACK_CYC;
  logic [7:0] low_q;
  logic [7:0] low_d;

  // Length of the acknowledge pulse now running
  always_comb low_d = ack_n ? 8'h00 : low_q + 8'h01;
  always_ff @(posedge clk) low_q <= rst ? 8'h00 : low_d;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Busy answers a strobe within a few cycles of the synchroniser
  sequence s_took;
    ##[2:8] busy;
  endsequence
  sequence s_init;
    ##[2:10] mode == 2'b00;
  endsequence

  property p_status;
    !$past(rst) && mode == 2'b00 && $past(mode) == 2'b00
      |-> fault_n == !($past(paper_out) || $past(alarm))
      && paper_end == $past(paper_out);
  endproperty
  a_status: assert property (p_status)
    else $error("fault or paper end wrong");
  property p_alarm;
    !$past(rst) && $past(alarm) && mode != 2'b01 |-> busy;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("busy low during alarm");
  property p_ack_len;
    $rose(ack_n) && !$past(rst) |-> low_q == ACK;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("acknowledge pulse length wrong");
  property p_ack_busy;
    !ack_n && mode != 2'b01 |-> busy;
  endproperty
  a_ack_busy: assert property (p_ack_busy)
    else $error("busy low during acknowledge");
  property p_ack_end;
    $rose(ack_n) && mode == 2'b00 |-> busy;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("busy dropped before acknowledge ended");
  property p_take;
    mode != 2'b01 && $fell(strobe_n) && !busy && !alarm |-> s_took;
  endproperty
  a_take: assert property (p_take)
    else $error("strobe not answered by busy");
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive word not held");
  property p_init;
    init_enable && $fell(init_n) |-> s_init;
  endproperty
  a_init: assert property (p_init)
    else $error("init did not return to compatibility");
  property p_mode;
    mode != 2'b11;
  endproperty
  a_mode: assert property (p_mode)
    else $error("illegal mode code");
endmodule // pph_sva
`default_nettype wire

// >>> verification/pph_host.sv
// Host computer model driving the parallel port lines
`default_nettype none
module pph_host (
  // Clock and answers from the port
  input wire logic       clk,
  input wire logic       ack_n,
  input wire logic       busy,
  input wire logic       paper_end,
  input wire logic       select,
  input wire logic       fault_n,
  // Lines driven toward the port
  output var logic       strobe_n,
  output var logic [7:0] data_in,
  output var logic       auto_feed_n,
  output var logic       select_in,
  output var logic       init_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int tmo = 0;

  // Idle lines from time zero
  initial begin
    strobe_n = 1'b1;
    data_in = 8'h5a;
    auto_feed_n = 1'b1;
    select_in = 1'b0;
    init_n = 1'b1;
  end

  // Bounded wait on acknowledge or busy; running out is counted
  task automatic wt(input bit on_ack, input logic v);
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk);
      if ((on_ack ? ack_n : busy) === v) return;
    end
    tmo++;
  endtask

  // Forward byte: data settles first, strobe held until busy answers
  task automatic xfer(input logic [7:0] d, input bit wrel, input bit cmd);
    data_in = d;
    auto_feed_n = !cmd; // ECP qualifier: low marks a command
    repeat (5) @(negedge clk);
    strobe_n = 1'b0;
    wt(0, 1);
    strobe_n = 1'b1;
    data_in = ~d; // Released lines no longer show the byte
    if (wrel) wt(0, 0);
    auto_feed_n = 1'b1;
  endtask

  // Reverse nibble: host ready low, status lines read during acknowledge
  task automatic nib(output logic [3:0] n);
    auto_feed_n = 1'b0;
    wt(1, 0);
    n = {busy, paper_end, select, fault_n};
    wt(1, 1);
    auto_feed_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // Mode request: select in high, then auto feed low
  task automatic neg(input logic [7:0] d);
    data_in = d;
    select_in = 1'b1;
    repeat (5) @(negedge clk);
    auto_feed_n = 1'b0;
    wt(1, 0);
    wt(1, 1);
    auto_feed_n = 1'b1;
    wt(0, 0);
  endtask

  // Leave the requested mode
  task automatic quit();
    select_in = 1'b0;
  endtask

  // Initializing pulse
  task automatic init_pulse();
    init_n = 1'b0;
    repeat (10) @(negedge clk);
    init_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask
endmodule // pph_host
`default_nettype wire

// >>> verification/printer_parallel_host_port_tb_top.sv
// Self-checking bench for the printer parallel host port
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module printer_parallel_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       paper_out = 1'b0, alarm = 1'b0, online = 1'b1;
  logic       init_enable = 1'b0, rx_ready = 1'b0, rx_release = 1'b0;
  logic [2:0] buf_size_sel = 3'h0;
  wire logic  strobe_n, auto_feed_n, select_in, init_n, ack_n, busy;
  wire logic  paper_end, select, fault_n, rx_valid, rx_command, tx_ready;
  wire logic [7:0] data_in, rx_data;
  wire logic [1:0] mode;
  logic [8:0] exp_q[$];
  logic [8:0] w;
  logic [3:0] nb;
  logic       tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  int         seed = 89549, n_errors = 0, num_checks = 0, drn = 0, rel = 0;
  int         n_tx = 0;
  bit         stall = 1'b0;

  pph_port dut (.clk(clk), .rst(rst), .strobe_n(strobe_n),
    .data_in(data_in), .auto_feed_n(auto_feed_n), .select_in(select_in),
    .init_n(init_n), .ack_n(ack_n), .busy(busy), .paper_end(paper_end),
    .select(select), .fault_n(fault_n), .paper_out(paper_out),
    .alarm(alarm), .online(online), .init_enable(init_enable),
    .buf_size_sel(buf_size_sel), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_command(rx_command), .rx_release(rx_release),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .mode(mode));
  pph_host host (.clk(clk), .ack_n(ack_n), .busy(busy),
    .paper_end(paper_end), .select(select), .fault_n(fault_n),
    .strobe_n(strobe_n), .data_in(data_in), .auto_feed_n(auto_feed_n),
    .select_in(select_in), .init_n(init_n));

  // Clock at 125 MHz
  initial forever #4 clk = ~clk;

  // Drain side: pick ready and release, then check the word that the
  // next rising edge takes; also count finished reverse bytes
  always @(negedge clk) begin
    rx_ready = !stall && $random(seed) % 3 != 0;
    rx_release = !rx_release && rel < drn && $random(seed) % 2 == 0;
    if (rx_release) rel++;
    if (tx_ready === 1'b1) n_tx++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      drn++;
      w = exp_q.size() != 0 ? exp_q.pop_front() : 9'h1xx;
      `CHK({rx_command, rx_data}, w)
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // A host wait that ran out ends the run
  task automatic tmo_chk();
    if (host.tmo != 0) begin
      n_errors += host.tmo;
      final_report();
    end
  endtask

  task automatic snd(input logic [7:0] v, input bit wrel, input bit cmd);
    exp_q.push_back({cmd, v});
    host.xfer(v, wrel, cmd);
    tmo_chk();
  endtask

  // Main sequence
  initial begin
    buf_size_sel = 3'($random(seed));
    repeat (10) @(negedge clk);
    `CHK({ack_n, busy, tx_ready, rx_valid, mode}, 6'h30)
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // Status lines for every paper and alarm combination
    for (int i = 0; i < 4; i++) begin
      {paper_out, alarm} = 2'(i);
      online = 1'($random(seed));
      repeat (3) @(negedge clk);
      `CHK({fault_n, paper_end, select}, {i == 0, paper_out, online})
      `CHK(busy, alarm)
    end
    {paper_out, alarm} = 2'b00;
    // Compatibility bytes, edge values first, back to back
    for (int i = 0; i < 12; i++)
      snd(i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed)), 1'b1, 1'b0);
    repeat (20) @(negedge clk);
    // Drain held off: the eighth byte fills the buffer, busy must stay
    stall = 1'b1;
    for (int i = 0; i < 8; i++) snd(8'($random(seed)), i < 7, 1'b0);
    repeat (200) @(negedge clk);
    `CHK(busy, 1'b1)
    stall = 1'b0;
    host.wt(0, 0);
    tmo_chk();
    // ECP request, then bytes on the short handshake
    host.neg(8'h10);
    tmo_chk();
    `CHK(mode, 2'b10)
    // Third ECP unit carries the command qualifier
    for (int i = 0; i < 6; i++) snd(8'($random(seed)), 1'b1, i == 2);
    repeat (20) @(negedge clk);
    // Initializing pulse ignored while disabled, honoured when enabled
    host.init_pulse();
    `CHK(mode, 2'b10)
    init_enable = 1'b1;
    host.init_pulse();
    `CHK(mode, 2'b00)
    // Nibble request, then leave back to compatibility
    host.neg(8'h00);
    tmo_chk();
    `CHK(mode, 2'b01)
    // Reverse byte as two nibbles, low first, then one ready pulse
    repeat (10) @(negedge clk);
    tx_data = 8'($random(seed));
    tx_valid = 1'b1;
    host.nib(nb);
    `CHK(nb, tx_data[3:0])
    host.nib(nb);
    tmo_chk();
    `CHK(nb, tx_data[7:4])
    tx_valid = 1'b0;
    `CHK(n_tx, 1)
    host.quit();
    repeat (10) @(negedge clk);
    `CHK(mode, 2'b00)
    repeat (50) @(negedge clk);
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule // printer_parallel_host_port_tb_top

bind pph_port pph_sva u_sva (.*);
`default_nettype wire
